// >>> hdl/fcs_flash_command_sequencer.sv
// Flash command sequencer with AHB-Lite slave, status flags and array control
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fcs_flash_command_sequencer #(
    parameter int unsigned NSECT       = 8,
    parameter int unsigned SECT_LSB    = 14,
    parameter logic [31:0] FLASH_BYTES = 32'h0002_0000,
    parameter int unsigned LIMIT_CYC   = 400000
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    output logic [31:0]            arr_raddr,
    input  wire logic [31:0]       arr_rdata,
    output logic                   arr_prog,
    output logic [31:0]            arr_op_addr,
    output logic [15:0]            arr_wdata,
    output logic                   arr_erase,
    output logic                   arr_chip,
    output logic [NSECT:0]         arr_mask,
    output logic                   arr_hold,
    output logic                   arr_abort,
    input  wire logic              arr_done,
    output logic                   flash_ready_bit,
    output logic [1:0]             access_size_field
);

    localparam logic [31:0] LIMIT_LAST = 32'(LIMIT_CYC - 1);
    localparam logic [fcs_pkg::WIN_W-1:0] WIN_LAST =
        fcs_pkg::WIN_W'(fcs_pkg::ERASE_WINDOW_CYC - 1);

    fcs_pkg::fcs_state_e state;

    logic                        dph_act;
    logic [31:0]                 dph_addr;
    logic                        dph_wr;
    logic [2:0]                  dph_size;
    logic [2:0]                  stage;
    logic [NSECT:0]              erase_mask;
    logic                        op_bit7;
    logic                        time_limit_flag;
    logic                        launched;
    logic                        alt;
    logic                        alt2;
    logic [fcs_pkg::WIN_W-1:0]   win_cnt;
    logic [31:0]                 lim_cnt;

    logic                        step;
    logic                        wr_ev;
    logic                        rd_ev;
    logic                        dph_flash;
    logic                        dph_reg;
    logic                        cmd_ok;
    logic [7:0]                  cmd_d;
    logic [15:0]                 cmd_a;
    logic [15:0]                 wr_half;
    logic                        sel_hit;
    logic                        flag_view;
    logic [7:0]                  flags;
    logic [31:0]                 rd_value;

    // Flash array plus the security/trim word pair
    function automatic logic in_flash(input logic [31:0] a);
        in_flash = (a < FLASH_BYTES) || (a[31:3] == fcs_pkg::SEC_CODE_ADDR[31:3]);
    endfunction

    // Security code and trim share one sector bit, so neither erases alone
    function automatic logic [NSECT:0] sect_of(input logic [31:0] a);
        logic [NSECT:0] m;
        m = '0;
        if (a[31:3] == fcs_pkg::SEC_CODE_ADDR[31:3]) begin
            m[NSECT] = 1'b1;
        end else begin
            m[a[SECT_LSB +: $clog2(NSECT)]] = 1'b1;
        end
        return m;
    endfunction

    assign step      = ce & dph_act & ~hreadyout;
    assign wr_ev     = step & dph_wr;
    assign rd_ev     = step & ~dph_wr;
    assign dph_flash = in_flash(dph_addr);
    assign dph_reg   = (dph_addr[31:4] == fcs_pkg::REG_BASE[31:4]);
    assign wr_half   = dph_addr[1] ? hwdata[31:16] : hwdata[15:0];
    assign cmd_d     = wr_half[7:0];
    assign cmd_a     = dph_addr[15:0];
    assign cmd_ok    = wr_ev & dph_flash & (dph_size == fcs_pkg::HSIZE_HALF)
                     & (access_size_field == fcs_pkg::ASZ_PROG);
    assign sel_hit   = |(sect_of(dph_addr) & erase_mask);

    // Word reads and ROM mode always see the array
    assign flag_view = dph_flash && (access_size_field == fcs_pkg::ASZ_PROG)
                     && (dph_size != fcs_pkg::HSIZE_WORD) && (state != fcs_pkg::ST_READ)
                     && !((state == fcs_pkg::ST_SUSP) && !sel_hit);

    always_comb begin
        flags = 8'h00;
        unique case (state)
            fcs_pkg::ST_PROG: begin
                flags[fcs_pkg::FLG_POLL]  = ~op_bit7;
                flags[fcs_pkg::FLG_ALT]   = alt;
                flags[fcs_pkg::FLG_LIMIT] = time_limit_flag;
            end
            fcs_pkg::ST_CHIP, fcs_pkg::ST_SE_RUN: begin
                flags[fcs_pkg::FLG_ALT]   = alt;
                flags[fcs_pkg::FLG_LIMIT] = time_limit_flag;
                flags[fcs_pkg::FLG_WIN]   = 1'b1;
                flags[fcs_pkg::FLG_ALT2]  = alt2;
            end
            fcs_pkg::ST_SE_WIN: begin
                flags[fcs_pkg::FLG_ALT]   = alt;
                flags[fcs_pkg::FLG_ALT2]  = alt2;
            end
            fcs_pkg::ST_SUSP: begin
                flags[fcs_pkg::FLG_WIN]   = 1'b1;
                flags[fcs_pkg::FLG_ALT2]  = alt2;
            end
            fcs_pkg::ST_READ: begin
                flags = 8'h00;
            end
        endcase
    end

    always_comb begin
        rd_value = 32'h0000_0000;
        if (dph_reg) begin
            if (dph_addr[3:0] == fcs_pkg::OFS_ASZ) begin
                rd_value = {30'h0, access_size_field};
            end else if (dph_addr[3:0] == fcs_pkg::OFS_STAT) begin
                rd_value[fcs_pkg::STAT_RDY_POS] = flash_ready_bit;
            end
        end else if (flag_view) begin
            rd_value = {4{flags}};
        end else if (dph_flash) begin
            rd_value = arr_rdata;
        end
    end

    // Bus slave: one wait state on every transfer gives the array a cycle to answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_act   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
            dph_addr  <= 32'h0000_0000;
            dph_wr    <= 1'b0;
            dph_size  <= 3'h0;
            arr_raddr <= 32'h0000_0000;
        end else if (ce) begin
            hresp <= 1'b0;
            if (hsel && htrans[1] && hready) begin
                dph_act   <= 1'b1;
                hreadyout <= 1'b0;
                dph_addr  <= haddr;
                dph_wr    <= hwrite;
                dph_size  <= hsize;
                arr_raddr <= {haddr[31:2], 2'b00};
            end else if (step) begin
                dph_act   <= 1'b0;
                hreadyout <= 1'b1;
                if (!dph_wr) begin
                    hrdata <= rd_value;
                end
            end
        end
    end

    // Access mode register; reset always lands in ROM mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            access_size_field <= fcs_pkg::ASZ_ROM;
        end else if (ce && wr_ev && dph_reg && dph_addr[3:0] == fcs_pkg::OFS_ASZ) begin
            access_size_field <= wr_half[1:0];
        end
    end

    // Alternating flags move only on reads that actually show them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alt  <= 1'b0;
            alt2 <= 1'b0;
        end else if (ce && rd_ev && flag_view) begin
            if (state != fcs_pkg::ST_SUSP) begin
                alt <= ~alt;
            end
            if (state != fcs_pkg::ST_PROG) begin
                alt2 <= ~alt2;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_ready_bit <= 1'b1;
            arr_hold        <= 1'b0;
        end else if (ce) begin
            flash_ready_bit <= (state == fcs_pkg::ST_READ);
            arr_hold        <= (state == fcs_pkg::ST_SUSP);
        end
    end

    // Command decoder and algorithm control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= fcs_pkg::ST_READ;
            stage       <= fcs_pkg::STG_IDLE;
            erase_mask  <= '0;
            op_bit7     <= 1'b0;
            time_limit_flag        <= 1'b0;
            launched    <= 1'b0;
            win_cnt     <= '0;
            lim_cnt     <= 32'h0000_0000;
            arr_prog    <= 1'b0;
            arr_erase   <= 1'b0;
            arr_abort   <= 1'b0;
            arr_chip    <= 1'b0;
            arr_mask    <= '0;
            arr_op_addr <= 32'h0000_0000;
            arr_wdata   <= 16'h0000;
        end else if (ce) begin
            arr_prog  <= 1'b0;
            arr_erase <= 1'b0;
            arr_abort <= 1'b0;
            unique case (state)
                fcs_pkg::ST_READ: begin
                    if (cmd_ok) begin
                        stage <= fcs_pkg::STG_IDLE;
                        if (stage == fcs_pkg::STG_PDATA) begin
                            // Odd address is passed on untouched; host must keep it even
                            arr_prog    <= 1'b1;
                            arr_op_addr <= dph_addr;
                            arr_wdata   <= wr_half;
                            op_bit7     <= wr_half[7];
                            state       <= fcs_pkg::ST_PROG;
                            lim_cnt     <= 32'h0000_0000;
                            time_limit_flag        <= 1'b0;
                        end else if (cmd_d == fcs_pkg::CMD_RESET) begin
                            stage <= fcs_pkg::STG_IDLE;
                        end else if (stage == fcs_pkg::STG_IDLE && cmd_a == fcs_pkg::ADDR_UNLOCK1
                                     && cmd_d == fcs_pkg::CMD_AA) begin
                            stage <= fcs_pkg::STG_U2;
                        end else if (stage == fcs_pkg::STG_U2 && cmd_a == fcs_pkg::ADDR_UNLOCK2
                                     && cmd_d == fcs_pkg::CMD_55) begin
                            stage <= fcs_pkg::STG_CMD;
                        end else if (stage == fcs_pkg::STG_CMD && cmd_a == fcs_pkg::ADDR_UNLOCK1
                                     && cmd_d == fcs_pkg::CMD_PROG) begin
                            stage <= fcs_pkg::STG_PDATA;
                        end else if (stage == fcs_pkg::STG_CMD && cmd_a == fcs_pkg::ADDR_UNLOCK1
                                     && cmd_d == fcs_pkg::CMD_ERASE) begin
                            stage <= fcs_pkg::STG_E_AA;
                        end else if (stage == fcs_pkg::STG_E_AA && cmd_a == fcs_pkg::ADDR_UNLOCK1
                                     && cmd_d == fcs_pkg::CMD_AA) begin
                            stage <= fcs_pkg::STG_E_55;
                        end else if (stage == fcs_pkg::STG_E_55 && cmd_a == fcs_pkg::ADDR_UNLOCK2
                                     && cmd_d == fcs_pkg::CMD_55) begin
                            stage <= fcs_pkg::STG_E_END;
                        end else if (stage == fcs_pkg::STG_E_END && cmd_a == fcs_pkg::ADDR_UNLOCK1
                                     && cmd_d == fcs_pkg::CMD_CHIP) begin
                            arr_erase <= 1'b1;
                            arr_chip  <= 1'b1;
                            arr_mask  <= '1;
                            state     <= fcs_pkg::ST_CHIP;
                            lim_cnt   <= 32'h0000_0000;
                            time_limit_flag      <= 1'b0;
                        end else if (stage == fcs_pkg::STG_E_END
                                     && cmd_d == fcs_pkg::CMD_SECT) begin
                            erase_mask <= sect_of(dph_addr);
                            arr_chip   <= 1'b0;
                            win_cnt    <= '0;
                            launched   <= 1'b0;
                            state      <= fcs_pkg::ST_SE_WIN;
                        end
                    end
                end
                fcs_pkg::ST_SE_WIN: begin
                    if (cmd_ok && cmd_d == fcs_pkg::CMD_SUSPEND) begin
                        state <= fcs_pkg::ST_SUSP;
                    end else if (cmd_ok && cmd_d == fcs_pkg::CMD_SECT) begin
                        // Each added sector reopens the window
                        erase_mask <= erase_mask | sect_of(dph_addr);
                        win_cnt    <= '0;
                    end else if (win_cnt == WIN_LAST) begin
                        arr_erase <= 1'b1;
                        arr_mask  <= erase_mask;
                        launched  <= 1'b1;
                        lim_cnt   <= 32'h0000_0000;
                        time_limit_flag      <= 1'b0;
                        state     <= fcs_pkg::ST_SE_RUN;
                    end else begin
                        win_cnt <= win_cnt + 1'b1;
                    end
                end
                fcs_pkg::ST_SUSP: begin
                    if (cmd_ok && cmd_d == fcs_pkg::CMD_SECT) begin
                        state <= fcs_pkg::ST_SE_RUN;
                        if (!launched) begin
                            arr_erase <= 1'b1;
                            arr_mask  <= erase_mask;
                            launched  <= 1'b1;
                            lim_cnt   <= 32'h0000_0000;
                            time_limit_flag      <= 1'b0;
                        end
                    end
                end
                fcs_pkg::ST_PROG, fcs_pkg::ST_CHIP, fcs_pkg::ST_SE_RUN: begin
                    if (time_limit_flag && cmd_ok && cmd_d == fcs_pkg::CMD_RESET) begin
                        arr_abort <= 1'b1;
                        time_limit_flag      <= 1'b0;
                        state     <= fcs_pkg::ST_READ;
                    end else if (arr_done && !time_limit_flag) begin
                        state <= fcs_pkg::ST_READ;
                    end else if (state == fcs_pkg::ST_SE_RUN && cmd_ok
                                 && cmd_d == fcs_pkg::CMD_SUSPEND) begin
                        state <= fcs_pkg::ST_SUSP;
                    end else if (lim_cnt == LIMIT_LAST) begin
                        time_limit_flag <= 1'b1;
                    end else begin
                        lim_cnt <= lim_cnt + 32'h1;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_reset_cmd;
        cmd_ok && cmd_d == fcs_pkg::CMD_RESET && state == fcs_pkg::ST_READ
            && stage != fcs_pkg::STG_PDATA |=> state == fcs_pkg::ST_READ && stage == 3'h0;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset write left a sequence open");

    property p_prog_launch;
        cmd_ok && state == fcs_pkg::ST_READ && stage == fcs_pkg::STG_PDATA
            |=> arr_prog && state == fcs_pkg::ST_PROG ##1 !arr_prog;
    endproperty
    a_prog_launch: assert property (p_prog_launch) else $error("program not launched once");

    property p_window;
        state == fcs_pkg::ST_SE_WIN ##1 state == fcs_pkg::ST_SE_RUN
            |-> $past(win_cnt) == WIN_LAST;
    endproperty
    a_window: assert property (p_window) else $error("sector erase began before window end");

    property p_suspend_ignored;
        cmd_ok && cmd_d == fcs_pkg::CMD_SUSPEND && !arr_done && !time_limit_flag
            && (state == fcs_pkg::ST_PROG || state == fcs_pkg::ST_CHIP)
            |=> state != fcs_pkg::ST_SUSP;
    endproperty
    a_suspend_ignored: assert property (p_suspend_ignored) else $error("suspend taken outside erase");

    property p_resume;
        cmd_ok && cmd_d == fcs_pkg::CMD_SECT && state == fcs_pkg::ST_SUSP
            |=> state == fcs_pkg::ST_SE_RUN ##1 !arr_hold;
    endproperty
    a_resume: assert property (p_resume) else $error("resume did not restart erase");

    property p_rom_mode;
        wr_ev && dph_flash && access_size_field != fcs_pkg::ASZ_PROG
            && state == fcs_pkg::ST_READ |=> $stable(stage) && state == fcs_pkg::ST_READ;
    endproperty
    a_rom_mode: assert property (p_rom_mode) else $error("command taken in ROM mode");

    property p_out_of_range;
        wr_ev && !dph_flash && state == fcs_pkg::ST_READ |=> $stable(stage);
    endproperty
    a_out_of_range: assert property (p_out_of_range) else $error("out of range write decoded");

    property p_prog_poll;
        rd_ev && flag_view && state == fcs_pkg::ST_PROG
            |=> hrdata[fcs_pkg::FLG_POLL] == !op_bit7 && hreadyout;
    endproperty
    a_prog_poll: assert property (p_prog_poll) else $error("program poll bit wrong");

    // Ready bit is registered from the state of the same edge
    property p_ready_bit;
        state != fcs_pkg::ST_READ && ce |=> !flash_ready_bit;
    endproperty
    a_ready_bit: assert property (p_ready_bit) else $error("ready bit high while busy");

    property p_erase_poll;
        rd_ev && flag_view && (state == fcs_pkg::ST_CHIP || state == fcs_pkg::ST_SE_RUN)
            |=> !hrdata[fcs_pkg::FLG_POLL] && hrdata[fcs_pkg::FLG_WIN];
    endproperty
    a_erase_poll: assert property (p_erase_poll) else $error("erase flags wrong");

    c_prog_done:  cover property (state == fcs_pkg::ST_PROG ##1 state == fcs_pkg::ST_READ);
    c_chip_erase: cover property (arr_erase && arr_chip);
    c_se_launch:  cover property (state == fcs_pkg::ST_SE_WIN ##1 state == fcs_pkg::ST_SE_RUN);
    c_suspend:    cover property (state == fcs_pkg::ST_SUSP ##1 state == fcs_pkg::ST_SE_RUN);

endmodule

`default_nettype wire

// >>> hdl/fcs_pkg.sv
// Constants and types for the flash command sequencer
package fcs_pkg;

    localparam int CLK_PERIOD_NS    = 25;
    localparam int ERASE_WINDOW_NS  = 35000;
    localparam int ERASE_WINDOW_CYC = (ERASE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIN_W            = $clog2(ERASE_WINDOW_CYC + 1);

    localparam logic [15:0] ADDR_UNLOCK1 = 16'h0aa8;
    localparam logic [15:0] ADDR_UNLOCK2 = 16'h0554;
    localparam logic [7:0]  CMD_AA       = 8'haa;
    localparam logic [7:0]  CMD_55       = 8'h55;
    localparam logic [7:0]  CMD_PROG     = 8'ha0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_CHIP     = 8'h10;
    localparam logic [7:0]  CMD_SECT     = 8'h30;
    localparam logic [7:0]  CMD_RESET    = 8'hf0;
    localparam logic [7:0]  CMD_SUSPEND  = 8'hb0;

    localparam logic [31:0] SEC_CODE_ADDR = 32'h0010_0000;
    localparam logic [31:0] TRIM_ADDR     = 32'h0010_0004;

    localparam logic [31:0] REG_BASE     = 32'h4000_0000;
    localparam logic [3:0]  OFS_ASZ      = 4'h0;
    localparam logic [3:0]  OFS_STAT     = 4'h4;
    localparam logic [1:0]  ASZ_ROM      = 2'b10;
    localparam logic [1:0]  ASZ_PROG     = 2'b01;
    localparam int          STAT_RDY_POS = 0;

    localparam int FLG_POLL  = 7;
    localparam int FLG_ALT   = 6;
    localparam int FLG_LIMIT = 5;
    localparam int FLG_WIN   = 3;
    localparam int FLG_ALT2  = 2;

    localparam logic [2:0] HSIZE_BYTE = 3'b000;
    localparam logic [2:0] HSIZE_HALF = 3'b001;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

    localparam logic [2:0] STG_IDLE  = 3'h0;
    localparam logic [2:0] STG_U2    = 3'h1;
    localparam logic [2:0] STG_CMD   = 3'h2;
    localparam logic [2:0] STG_PDATA = 3'h3;
    localparam logic [2:0] STG_E_AA  = 3'h4;
    localparam logic [2:0] STG_E_55  = 3'h5;
    localparam logic [2:0] STG_E_END = 3'h6;

    typedef enum logic [5:0] {
        ST_READ   = 6'b000001,
        ST_PROG   = 6'b000010,
        ST_CHIP   = 6'b000100,
        ST_SE_WIN = 6'b001000,
        ST_SE_RUN = 6'b010000,
        ST_SUSP   = 6'b100000
    } fcs_state_e;

endpackage

// >>> sim/fcs_array_model.sv
// Behavioural flash array and erase/program engine
`timescale 1ns/1ps
`default_nettype none
module fcs_array_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [31:0] arr_raddr,
    output logic      [31:0] arr_rdata,
    input  wire logic        arr_prog,
    input  wire logic [31:0] arr_op_addr,
    input  wire logic [15:0] arr_wdata,
    input  wire logic        arr_erase,
    input  wire logic        arr_hold,
    input  wire logic        arr_abort,
    input  wire logic        hang,
    output logic             arr_done
);
    logic [31:0] m [0:255];
    int          cnt;
    assign arr_rdata = m[arr_raddr[9:2]];
    // A hung engine never finishes; only an abort or a reset clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            arr_done <= 1'b0;
            for (int i = 0; i < 256; i++) m[i] <= 32'hc3c3_c3c3;
        end else begin
            arr_done <= 1'b0;
            if (arr_prog) begin
                m[arr_op_addr[9:2]][{arr_op_addr[1], 4'h0} +: 16] <= arr_wdata;
                cnt <= 40;
            end else if (arr_erase) begin
                for (int i = 0; i < 256; i++) m[i] <= 32'hffff_ffff;
                cnt <= 40;
            end else if (arr_abort) begin
                cnt <= 0;
            end else if (cnt > 0 && !hang && !arr_hold) begin
                cnt <= cnt - 1;
                arr_done <= (cnt == 1);
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic hclk, hresetn, hsel, ce, hwrite, hready, hreadyout, hresp, hang;
    logic arr_prog, arr_erase, arr_chip, arr_hold, arr_abort, arr_done, flash_ready_bit;
    logic [1:0] htrans, access_size_field;
    logic [2:0] hsize;
    logic [8:0] arr_mask;
    logic [15:0] arr_wdata;
    logic [31:0] haddr, hwdata, hrdata, arr_raddr, arr_rdata, arr_op_addr, r, q;
    int mismatches, n_checks;
    assign hsel = 1'b1;
    assign ce = 1'b1;
    assign hready = hreadyout;
    fcs_flash_command_sequencer #(.LIMIT_CYC(200)) u_dut (.*);
    fcs_array_model u_mem (.*);
    initial begin
        hclk = 0;
        forever #12.5 hclk = ~hclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds each phase until hready is sampled high
    task xfer(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [15:0] d);
        htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= s;
        @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00; hwdata <= {d, d};
        @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task wr(input logic [31:0] a, input logic [15:0] d); xfer(1, a, fcs_pkg::HSIZE_HALF, d); endtask
    // First flag read is kept in q and the second in r, so toggling bits can be compared
    task rd2(input logic [31:0] a);
        xfer(0, a, 3'b001, 0);
        q = r;
        xfer(0, a, 3'b001, 0);
    endtask
    // Upper data bytes vary since only the low byte is decoded
    task seq(input logic [31:0] hi, input logic [7:0] c, input logic [31:0] a3);
        wr(hi | 32'h0aa8, 16'hffaa);
        wr(hi | 32'h0554, 16'h1255);
        wr(a3, {8'h5a, c});
    endtask
    task wait_ready;
        for (int k = 0; k < 3000 && flash_ready_bit !== 1'b1; k++) @(posedge hclk);
        chk(flash_ready_bit, 1);
    endtask
    task t_mode;
        chk(access_size_field, 2'b10);
        seq(0, 8'ha0, 32'haa8); wr(32'h100, 16'h0001); repeat (3) @(posedge hclk);
        chk(flash_ready_bit, 1);
        wr(fcs_pkg::REG_BASE, 16'h0001); chk(access_size_field, 2'b01);
        seq(0, 8'h77, 32'haa8); wr(32'haa8, 16'h00a0); wr(32'h100, 16'h0001);
        seq(32'h0800_0000, 8'ha0, 32'h0800_0aa8); wr(32'h100, 16'h0001);
        repeat (3) @(posedge hclk); chk(flash_ready_bit, 1);
    endtask
    task t_prog;
        seq(0, 8'ha0, 32'haa8); wr(32'h100, 16'h0080);
        chk(arr_op_addr, 32'h100);
        chk(arr_wdata, 16'h0080);
        chk(hresp, 0);
        rd2(32'h100); chk(r[7:0] & 8'hac, 8'h00);
        chk(r[6], !q[6]);
        xfer(0, fcs_pkg::REG_BASE + 4, 3'b010, 0); chk(r[0], 0);
        xfer(0, 32'h104, 3'b010, 0); chk(r, 32'hc3c3_c3c3);
        wait_ready; xfer(0, 32'h100, 3'b001, 0); chk(r[15:0], 16'h0080);
    endtask
    task t_sector;
        seq(0, 8'h80, 32'haa8); seq(0, 8'h30, 32'h4000); wr(32'h8000, 16'h0030);
        rd2(32'h4000); chk(r[7:0] & 8'ha8, 8'h00);
        wr(0, 16'h00b0); rd2(0); chk(r, 32'hc3c3_c3c3);
        rd2(32'h4000); chk(r[7], 0);
        wr(0, 16'h0030); chk(arr_mask, 9'h006);
        rd2(32'h4000); chk(r[7:0] & 8'ha8, 8'h08);
        wr(0, 16'h00f0); chk(flash_ready_bit, 0);
        wait_ready; xfer(0, 32'h4000, 3'b001, 0); chk(r, 32'hffff_ffff);
    endtask
    task t_chip;
        seq(0, 8'h80, 32'haa8); seq(0, 8'h10, 32'haa8); wr(0, 16'h00b0);
        chk(arr_chip, 1);
        chk(arr_mask, 9'h1ff);
        rd2(0); chk(r[7:0] & 8'ha8, 8'h08);
        chk(r[6] ^ q[6], 1);
        wait_ready;
    endtask
    task t_limit;
        hang <= 1'b1; seq(0, 8'ha0, 32'haa8); wr(32'h102, 16'h0000);
        repeat (260) @(posedge hclk); rd2(0); chk(r[5], 1);
        wr(0, 16'h00f0); repeat (3) @(posedge hclk); chk(flash_ready_bit, 1);
        hang <= 1'b0;
    endtask
    // Erase of the security/trim pair, held hung so the window and limit flags can be read
    task t_window;
        hang <= 1'b1;
        seq(0, 8'h80, 32'haa8);
        seq(0, 8'h30, fcs_pkg::TRIM_ADDR);
        repeat (1300) @(posedge hclk);
        chk(flash_ready_bit, 0);
        chk(arr_mask, 9'h1ff);
        rd2(0); chk(r[7:0] & 8'ha8, 8'h00);
        repeat (400) @(posedge hclk);
        chk(arr_mask, 9'h100);
        rd2(0); chk(r[7:0] & 8'ha8, 8'h28);
        wr(0, 16'h00f0); repeat (3) @(posedge hclk); chk(flash_ready_bit, 1);
        hang <= 1'b0;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        print_verdict;
    end
    initial begin
        hresetn = 0; htrans = 0; haddr = 0; hwrite = 0; hsize = 0; hwdata = 0; hang = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_mode; t_prog; t_sector; t_chip; t_limit; t_window;
        print_verdict;
    end
endmodule
`default_nettype wire
